// file: rtl/qdac_defines.svh
// constants for the quad dac load and thermal output block
// What this block does
// - written dac codes wait in input registers until a load occurs
// - dac register reads return the active code, not the pending one
// - load comes from strobe pin falling edge, setup bits, or load register
// - strobe acts on edges only; must rise and fall again to reload
// - dac code is straight unsigned binary, output is ref times code over 2^N
// - each reference pair input is separately buffered or unbuffered in setup
// - load setup selects internal or external reference, external after reset
// - setup bits 0-3 pick gain one or two per dac
// - control bits make dac a follow internal and dac b external temperature
// - a following dac refreshes on each finished temperature measurement
// - thermal output is 8 bits per degree, or 10 bits per quarter degree
// - setup bits 0 and 1 also set the gain, and so the thermal span, of dac a and dac b
// - 8-bit two's complement offsets give the temperature shown at zero volts
// - thermal range spans -128 to +127, default zero code at -40
// - power-down switches every dac output off to high impedance
// - software load works only when the select bit is set; else the pin
// - thermal code saturates at full scale instead of wrapping
`ifndef QDAC_DEFINES_SVH
`define QDAC_DEFINES_SVH

`define QDAC_NUM_DAC        4
`define QDAC_DAC_BITS       12
`define QDAC_TEMP_BITS      10

`define QDAC_ADDR_DAC_BASE  8'h10
`define QDAC_ADDR_DAC_MASK  8'hF8
`define QDAC_ADDR_CTRL3     8'h1A
`define QDAC_ADDR_SETUP     8'h1B
`define QDAC_ADDR_LOAD      8'h1C
`define QDAC_ADDR_INT_OFS   8'h21
`define QDAC_ADDR_EXT_OFS   8'h22

`define QDAC_CTRL3_FINE     1
`define QDAC_CTRL3_SW_SEL   3
`define QDAC_CTRL3_FOL_INT  5
`define QDAC_CTRL3_FOL_EXT  6
`define QDAC_CTRL3_PWR_DN   7

`define QDAC_SETUP_SPAN_A   0
`define QDAC_SETUP_SPAN_B   1
`define QDAC_SETUP_SW_LO    4
`define QDAC_SETUP_SW_HI    5
`define QDAC_SETUP_STORE    8'hCF

`define QDAC_LOAD_REF_INT   4
`define QDAC_LOAD_STORE     8'h10

`define QDAC_CTRL3_RST      8'h00
`define QDAC_SETUP_RST      8'h00
`define QDAC_LOAD_RST       8'h00
`define QDAC_OFS_RST        8'hD8

`define QDAC_FINE_MAX       12'sh3FF
`define QDAC_COARSE_MAX     12'sh0FF
`define QDAC_FINE_FULL      12'hFFC
`define QDAC_COARSE_FULL    12'hFF0

`define QDAC_LOAD_PULSE_NS  20
`define QDAC_CLK_NS         100
`define QDAC_LOAD_PULSE_CYC ((`QDAC_LOAD_PULSE_NS + `QDAC_CLK_NS - 1) / `QDAC_CLK_NS)

`endif

// file: rtl/qdac_pkg.sv
// types shared by the quad dac load and thermal output block
package qdac_pkg;
   typedef logic [11:0] qdac_code_type;
   typedef logic [7:0]  qdac_byte_type;
   typedef logic [9:0]  qdac_temp_type;
endpackage

// file: rtl/qdac_top.sv
// quad dac register file, deferred load and thermal output
`timescale 1ns/1ns
`include "qdac_defines.svh"

module qdac_top
   import qdac_pkg::*;
(
   // clock and reset
   input  wire logic                ref_clk_i,
   input  wire logic                nrst_i,
   // load strobe pin
   input  wire logic                dac_load_strobe_n_i,
   // register port
   input  wire logic                reg_wr_i,
   input  wire logic                reg_rd_i,
   input  wire qdac_byte_type       reg_addr_i,
   input  wire qdac_byte_type       reg_wdata_i,
   output qdac_byte_type            reg_rdata_o,
   // temperature results
   input  wire qdac_temp_type       int_temp_i,
   input  wire logic                int_temp_valid_i,
   input  wire qdac_temp_type       ext_temp_i,
   input  wire logic                ext_temp_valid_i,
   // analog controls
   output qdac_code_type [3:0]      dac_code_o,
   output logic          [3:0]      gain_double_o,
   output logic          [1:0]      ref_unbuffered_o,
   output logic                     ref_internal_o,
   output logic                     dac_power_down_o
);

////////////////////////////////////////////////////////////////////////
// registers

   qdac_byte_type       ctrl3;
   qdac_byte_type       dac_setup;
   qdac_byte_type       load_setup;
   qdac_byte_type       internal_thermal_offset;
   qdac_byte_type       external_thermal_offset;
   qdac_code_type [3:0] in_code;
   logic          [2:0] pin_sync;
   logic                pin_level;

////////////////////////////////////////////////////////////////////////
// decode

   wire logic wr_ctrl3   = reg_wr_i && (reg_addr_i == `QDAC_ADDR_CTRL3);
   wire logic wr_setup   = reg_wr_i && (reg_addr_i == `QDAC_ADDR_SETUP);
   wire logic wr_load    = reg_wr_i && (reg_addr_i == `QDAC_ADDR_LOAD);
   wire logic wr_int_ofs = reg_wr_i && (reg_addr_i == `QDAC_ADDR_INT_OFS);
   wire logic wr_ext_ofs = reg_wr_i && (reg_addr_i == `QDAC_ADDR_EXT_OFS);
   wire logic is_dac     = (reg_addr_i & `QDAC_ADDR_DAC_MASK) == `QDAC_ADDR_DAC_BASE;

   wire logic sw_sel     = ctrl3[`QDAC_CTRL3_SW_SEL];
   wire logic fine_res   = ctrl3[`QDAC_CTRL3_FINE];
   wire logic follow_int = ctrl3[`QDAC_CTRL3_FOL_INT];
   wire logic follow_ext = ctrl3[`QDAC_CTRL3_FOL_EXT];

////////////////////////////////////////////////////////////////////////
// load strobe pin

   // change taken once second and third stages agree
   wire logic pin_agree = pin_sync[1] == pin_sync[2];
   // falling edge only; level low does nothing more
   wire logic pin_fall  = pin_level && pin_agree && !pin_sync[2];
   // pin governs updates only while software load is not selected
   wire logic pin_load  = pin_fall && !sw_sel;

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         pin_sync  <= 3'h7;
         pin_level <= 1'b1;
      end else begin
         pin_sync  <= {pin_sync[1:0], dac_load_strobe_n_i};
         if (pin_agree) begin
            pin_level <= pin_sync[2];
         end
      end
   end

////////////////////////////////////////////////////////////////////////
// thermal code

   // temperature minus offset, floored at zero, saturated at full scale
   function automatic qdac_code_type therm_code(
      input qdac_temp_type t,
      input qdac_byte_type o,
      input logic          fine
   );
      logic signed [11:0] d;
      logic signed [11:0] q;
      d = $signed({{2{t[9]}}, t}) - $signed({{2{o[7]}}, o, 2'b00});
      q = d >>> 2;
      if (d < 12'sh000) begin
         therm_code = '0;
      end else if (fine) begin
         // quarter degree steps, ten bits
         therm_code = (d > `QDAC_FINE_MAX) ? `QDAC_FINE_FULL : {d[9:0], 2'b00};
      end else begin
         // whole degree steps, eight bits
         therm_code = (q > `QDAC_COARSE_MAX) ? `QDAC_COARSE_FULL : {q[7:0], 4'h0};
      end
   endfunction

   wire qdac_code_type therm_int = therm_code(int_temp_i, internal_thermal_offset, fine_res);
   wire qdac_code_type therm_ext = therm_code(ext_temp_i, external_thermal_offset, fine_res);

   wire logic [3:0] follow = {2'b00, follow_ext, follow_int};
   wire logic [3:0] therm_upd = {2'b00, follow_ext && ext_temp_valid_i,
                                 follow_int && int_temp_valid_i};
   wire qdac_code_type [3:0] therm_src = {12'h000, 12'h000, therm_ext, therm_int};

////////////////////////////////////////////////////////////////////////
// per dac input and active code

   logic [3:0] sw_load;
   logic [3:0] load_vec;

   genvar n;
   generate
      for (n = 0; n < `QDAC_NUM_DAC; n++) begin : g_dac
         wire logic wr_lo = reg_wr_i && (reg_addr_i == 8'(`QDAC_ADDR_DAC_BASE + 2 * n));
         wire logic wr_hi = reg_wr_i && (reg_addr_i == 8'(`QDAC_ADDR_DAC_BASE + 2 * n + 1));
         wire logic sw_bit = (n < 2) ? reg_wdata_i[`QDAC_SETUP_SW_LO]
                                     : reg_wdata_i[`QDAC_SETUP_SW_HI];

         // setup bits or load register, only when selected
         assign sw_load[n]  = sw_sel && ((wr_setup && sw_bit) || (wr_load && reg_wdata_i[n]));
         assign load_vec[n] = pin_load || sw_load[n];

         always_ff @(posedge ref_clk_i) begin
            if (!nrst_i) begin
               in_code[n] <= '0;
            end else if (wr_lo) begin
               in_code[n][7:0] <= reg_wdata_i;
            end else if (wr_hi) begin
               in_code[n][11:8] <= reg_wdata_i[3:0];
            end
         end

         // output code changes only on load or thermal refresh
         always_ff @(posedge ref_clk_i) begin
            if (!nrst_i) begin
               dac_code_o[n] <= '0;
            end else if (therm_upd[n]) begin
               dac_code_o[n] <= therm_src[n];
            end else if (load_vec[n] && !follow[n]) begin
               dac_code_o[n] <= in_code[n];
            end
         end
      end
   endgenerate

////////////////////////////////////////////////////////////////////////
// control registers

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         ctrl3 <= `QDAC_CTRL3_RST;
      end else if (wr_ctrl3) begin
         ctrl3 <= reg_wdata_i;
      end
   end

   // load bits are one-shot and never stored
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         dac_setup <= `QDAC_SETUP_RST;
      end else if (wr_setup) begin
         dac_setup <= reg_wdata_i & `QDAC_SETUP_STORE;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         load_setup <= `QDAC_LOAD_RST;
      end else if (wr_load) begin
         load_setup <= reg_wdata_i & `QDAC_LOAD_STORE;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         internal_thermal_offset <= `QDAC_OFS_RST;
         external_thermal_offset <= `QDAC_OFS_RST;
      end else begin
         if (wr_int_ofs) begin
            internal_thermal_offset <= reg_wdata_i;
         end
         if (wr_ext_ofs) begin
            external_thermal_offset <= reg_wdata_i;
         end
      end
   end

////////////////////////////////////////////////////////////////////////
// analog control outputs

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         gain_double_o    <= '0;
         ref_unbuffered_o <= '0;
         ref_internal_o   <= 1'b0;
         dac_power_down_o <= 1'b0;
      end else begin
         // gain bits drive the gain outputs in every mode, so they also set the thermal span of a and b
         gain_double_o    <= dac_setup[3:0];
         ref_unbuffered_o <= dac_setup[7:6];
         ref_internal_o   <= load_setup[`QDAC_LOAD_REF_INT];
         dac_power_down_o <= ctrl3[`QDAC_CTRL3_PWR_DN];
      end
   end

////////////////////////////////////////////////////////////////////////
// readback

   wire qdac_code_type rd_code = dac_code_o[reg_addr_i[2:1]];
   // dac reads show the active code, not the pending one
   wire qdac_byte_type rd_dac  = reg_addr_i[0] ? {4'h0, rd_code[11:8]} : rd_code[7:0];

   wire qdac_byte_type rd_mux =
      is_dac                                ? rd_dac :
      (reg_addr_i == `QDAC_ADDR_CTRL3)      ? ctrl3 :
      (reg_addr_i == `QDAC_ADDR_SETUP)      ? dac_setup :
      (reg_addr_i == `QDAC_ADDR_LOAD)       ? load_setup :
      (reg_addr_i == `QDAC_ADDR_INT_OFS)    ? internal_thermal_offset :
      (reg_addr_i == `QDAC_ADDR_EXT_OFS)    ? external_thermal_offset :
                                              8'h00;

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rd_mux;
      end
   end

////////////////////////////////////////////////////////////////////////
// checks

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!nrst_i);

   output_hold_a: assert property (!load_vec[2] |=> $stable(dac_code_o[2]))
      else $error("dac c changed without a load");

   readback_active_a: assert property (
      reg_rd_i && reg_addr_i == 8'h14 |=> reg_rdata_o == $past(dac_code_o[2][7:0]))
      else $error("dac c readback is not the active code");

   pin_load_a: assert property (
      $fell(pin_level) && !$past(sw_sel) |-> dac_code_o[3] == $past(in_code[3]))
      else $error("strobe edge did not load dac d");

   pin_edge_once_a: assert property (
      pin_fall |=> !pin_fall [*2])
      else $error("strobe level loaded more than once");

   sw_gate_a: assert property (
      !sw_sel && !pin_fall && wr_load |=> $stable(dac_code_o[3]))
      else $error("software load acted while pin selected");

   sw_load_a: assert property (
      sw_sel && wr_load && reg_wdata_i[3] |=> dac_code_o[3] == $past(in_code[3]))
      else $error("load register did not load dac d");

   ref_default_a: assert property (
      disable iff (1'b0) !nrst_i |=> !ref_internal_o)
      else $error("reference not external after reset");

   gain_track_a: assert property (
      wr_setup |-> ##2 gain_double_o == $past(reg_wdata_i[3:0], 2))
      else $error("gain bits not applied");

   therm_follow_a: assert property (
      follow_int && int_temp_valid_i |=> dac_code_o[0] == $past(therm_int))
      else $error("dac a missed a temperature refresh");

   therm_floor_a: assert property (
      $signed(int_temp_i) < $signed({internal_thermal_offset, 2'b00}) |-> therm_int == 12'h000)
      else $error("thermal code not floored at zero");

   therm_sat_a: assert property (
      !fine_res && $signed(int_temp_i) == 10'sh1FC
      && internal_thermal_offset == 8'h80 |-> therm_int == `QDAC_COARSE_FULL)
      else $error("thermal code did not saturate");

   power_down_a: assert property (
      wr_ctrl3 && reg_wdata_i[`QDAC_CTRL3_PWR_DN] && !$past(wr_ctrl3) |-> ##2 dac_power_down_o)
      else $error("power-down not applied");

endmodule

// file: tb/qdac_host.sv
// host model driving the register port and the load strobe pin
`timescale 1ns/1ns
module qdac_host
   import qdac_pkg::*;
(
   // clock
   input  wire logic          ref_clk_i,
   // register port
   output logic               reg_wr_o,
   output logic               reg_rd_o,
   output qdac_byte_type      reg_addr_o,
   output qdac_byte_type      reg_wdata_o,
   input  wire qdac_byte_type reg_rdata_i,
   // load strobe
   output logic               strobe_n_o
);
   initial begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      strobe_n_o = 1'b1;
   end
   task automatic wr(input qdac_byte_type a, input qdac_byte_type d);
      @(posedge ref_clk_i);
      reg_wr_o <= 1'b1;
      reg_addr_o <= a;
      reg_wdata_o <= d;
      @(posedge ref_clk_i);
      reg_wr_o <= 1'b0;
      // released lines must not keep the last value
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask
   task automatic rd(input qdac_byte_type a, output qdac_byte_type d);
      @(posedge ref_clk_i);
      reg_rd_o <= 1'b1;
      reg_addr_o <= a;
      @(posedge ref_clk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      #1;
      d = reg_rdata_i;
   endtask
   // strobe only changes on edges; callers hold low several cycles
   task automatic pin(input logic v);
      @(posedge ref_clk_i);
      strobe_n_o <= v;
   endtask
endmodule

// file: tb/qdac_top_tb_top.sv
// self-checking bench for the quad dac block
`timescale 1ns/1ns
module qdac_top_tb_top
   import qdac_pkg::*;
;
   typedef struct {qdac_byte_type a; qdac_byte_type d; qdac_byte_type exp;} qdac_row_type;
   logic               clk, nrst, reg_wr, reg_rd, strobe_n, itemp_v, etemp_v, ref_int, pdn;
   qdac_byte_type      addr, wdata, rdata;
   qdac_temp_type      itemp, etemp;
   qdac_code_type [3:0] code;
   logic [3:0]         gain;
   logic [1:0]         unbuf;
   int                 checks = 0;
   int                 bad_count = 0;
   qdac_row_type rows [7] = '{'{8'h1B, 8'hFF, 8'hCF}, '{8'h1C, 8'hFF, 8'h10}, '{8'h21, 8'hD8, 8'hD8},
      '{8'h22, 8'h0A, 8'h0A}, '{8'h1A, 8'h00, 8'h00}, '{8'h3F, 8'h55, 8'h00}, '{8'h13, 8'hFF, 8'h00}};

   qdac_host u_host (.ref_clk_i(clk), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(addr),
      .reg_wdata_o(wdata), .reg_rdata_i(rdata), .strobe_n_o(strobe_n));
   qdac_top u_dut (.ref_clk_i(clk), .nrst_i(nrst), .dac_load_strobe_n_i(strobe_n), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .int_temp_i(itemp),
      .int_temp_valid_i(itemp_v), .ext_temp_i(etemp), .ext_temp_valid_i(etemp_v), .dac_code_o(code),
      .gain_double_o(gain), .ref_unbuffered_o(unbuf), .ref_internal_o(ref_int), .dac_power_down_o(pdn));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [11:0] exp, input logic [11:0] seen);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rdchk(input string name, input qdac_byte_type a, input qdac_byte_type exp);
      qdac_byte_type d;
      u_host.rd(a, d);
      check(name, {4'h0, exp}, {4'h0, d});
   endtask
   task automatic tpulse(input logic ext, input qdac_temp_type t);
      @(posedge clk);
      itemp <= t;
      etemp <= t;
      itemp_v <= ~ext;
      etemp_v <= ext;
      @(posedge clk);
      itemp_v <= 1'b0;
      etemp_v <= 1'b0;
      #1;
   endtask
   task automatic test_done;
      if (bad_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      test_done();
   end
   initial begin
      nrst = 1'b0;
      itemp = 10'h000;
      etemp = 10'h000;
      itemp_v = 1'b0;
      etemp_v = 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      step(1);
      check("code_rst", 12'h000, code[0]);
      rdchk("int_ofs_rst", 8'h21, 8'hD8);
      rdchk("load_rst", 8'h1C, 8'h00);
      check("ref_int_rst", 12'h000, {11'h000, ref_int});
      // offsets: -40 as D8h, +10 written directly
      foreach (rows[i]) begin
         u_host.wr(rows[i].a, rows[i].d);
         rdchk("row_read", rows[i].a, rows[i].exp);
      end
      step(2);
      check("gain", 12'h00F, {8'h00, gain});
      check("unbuf", 12'h003, {10'h000, unbuf});
      check("ref_int", 12'h001, {11'h000, ref_int});
      // pending code waits for a strobe fall
      u_host.wr(8'h10, 8'h23);
      u_host.wr(8'h11, 8'h01);
      step(3);
      check("code_pend", 12'h000, code[0]);
      rdchk("rd_pend", 8'h10, 8'h00);
      u_host.pin(1'b0);
      step(6);
      check("code_pin", 12'h123, code[0]);
      rdchk("rd_lo", 8'h10, 8'h23);
      rdchk("rd_hi", 8'h11, 8'h01);
      // strobe still low: a second write must not load
      u_host.wr(8'h10, 8'h56);
      u_host.wr(8'h11, 8'h04);
      step(4);
      check("held_low", 12'h123, code[0]);
      u_host.pin(1'b1);
      step(3);
      u_host.pin(1'b0);
      step(6);
      check("refall", 12'h456, code[0]);
      u_host.pin(1'b1);
      // software load without and with the select bit
      u_host.wr(8'h10, 8'h89);
      u_host.wr(8'h1C, 8'h11);
      step(2);
      check("sw_off", 12'h456, code[0]);
      u_host.wr(8'h1A, 8'h08);
      u_host.pin(1'b0);
      step(6);
      check("pin_off", 12'h456, code[0]);
      u_host.pin(1'b1);
      u_host.wr(8'h16, 8'h5A);
      u_host.wr(8'h1C, 8'h19);
      step(1);
      check("load_reg", 12'h489, code[0]);
      check("load_reg_d", 12'h05A, code[3]);
      u_host.wr(8'h14, 8'hAB);
      u_host.wr(8'h15, 8'h0C);
      rdchk("rd_c_pend", 8'h14, 8'h00);
      u_host.wr(8'h1B, 8'hEF);
      step(1);
      check("setup_load", 12'hCAB, code[2]);
      rdchk("rd_c", 8'h14, 8'hAB);
      // thermal follow: offset -40 internal, +10 external
      u_host.wr(8'h1A, 8'h68);
      tpulse(1'b0, 10'h065);
      check("therm_coarse", 12'h410, code[0]);
      u_host.wr(8'h1A, 8'h6A);
      tpulse(1'b0, 10'h065);
      check("therm_fine", 12'h414, code[0]);
      tpulse(1'b1, 10'h014);
      check("therm_floor", 12'h000, code[1]);
      tpulse(1'b1, 10'h07C);
      check("therm_ext", 12'h150, code[1]);
      u_host.wr(8'h1C, 8'h13);
      step(1);
      check("follow_noload", 12'h414, code[0]);
      u_host.wr(8'h1A, 8'hEA);
      step(2);
      check("pdn", 12'h001, {11'h000, pdn});
      check("pdn_code", 12'h414, code[0]);
      tpulse(1'b0, 10'h360);
      check("therm_m40", 12'h000, code[0]);
      // coarse top of range with offset -128
      u_host.wr(8'h1A, 8'h68);
      u_host.wr(8'h21, 8'h80);
      tpulse(1'b0, 10'h1FC);
      check("therm_sat", 12'hFF0, code[0]);
      // below the offset floors at zero
      u_host.wr(8'h21, 8'hD8);
      tpulse(1'b0, 10'h300);
      check("therm_floor_int", 12'h000, code[0]);
      // reset again in mid-run
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      step(1);
      check("code_c_rst2", 12'h000, code[2]);
      check("code_d_rst2", 12'h000, code[3]);
      check("ref_int_rst2", 12'h000, {11'h000, ref_int});
      check("gain_rst2", 12'h000, {8'h00, gain});
      rdchk("ext_ofs_rst2", 8'h22, 8'hD8);
      test_done();
   end
endmodule
